// File: src/fault_sup_params.svh
// constants for the dual-channel fault supervisor
`ifndef FAULT_SUP_PARAMS_SVH
`define FAULT_SUP_PARAMS_SVH
// register byte offsets
`define OFF_FAULT0   8'h00
`define OFF_FAULT1   8'h04
`define OFF_CTRL     8'h08
`define OFF_CHECK0   8'h0c
`define OFF_CHECK1   8'h10
`define OFF_SETUP0   8'h14
`define OFF_SETUP1   8'h18
// fault register bits
`define FB_OV        0
`define FB_OC        1
`define FB_OL        2
`define FB_SHORT     3
`define FB_OVLAT     4
// control register bits
`define DB_CLR       0
`define DB_TW        1
`define DB_TSD       2
// check register fields
`define CB_START     0
`define CB_DONE      1
`define CB_RES_LO    2
`define CB_RES_HI    3
`define CB_MONSEL    4
`define CB_DAC_LO    8
`define CB_DAC_HI    15
// reset values
`define SHORT_CODE_RST 4'h2
`define DAC_RST        8'h00
// timing and thresholds
`define CLK_PERIOD_NS  10
`define CHECK_TIME_NS  200
`define CHECK_CYCLES   (`CHECK_TIME_NS / `CLK_PERIOD_NS)
`define OL_CYCLES      3'h7
`define WIN_MARGIN     8'h04
`define SHORT_TOP      5'h10
`endif

// File: src/fault_sup_pkg.sv
// types shared by the fault supervisor
`default_nettype none
package fault_sup_pkg;
    typedef enum logic [0:0] {
        CHK_IDLE = 1'b0,
        CHK_RUN  = 1'b1
    } check_state_t;
    typedef enum logic [1:0] {
        WIN_BELOW = 2'b00,
        WIN_INSIDE = 2'b01,
        WIN_ABOVE = 2'b10,
        WIN_FAR   = 2'b11
    } window_t;
endpackage
`default_nettype wire

// File: src/fault_supervisor.sv
// dual-channel fault supervision with apb register access
`include "fault_sup_params.svh"
`default_nettype none
module fault_supervisor #(
    parameter int CHK_W = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  topology_select,
    input  wire logic [1:0]  pwm_dim,
    input  wire logic [1:0]  ov_above,
    input  wire logic [1:0]  ov_below_hys,
    input  wire logic [1:0]  oc_above_rise,
    input  wire logic [1:0]  oc_below_fall,
    input  wire logic [1:0]  ol_fb_high,
    input  wire logic [1:0]  ol_shunt_low,
    input  wire logic [1:0]  short_detect,
    input  wire logic [1:0]  soft_start_level,
    input  wire logic        temp_warn,
    input  wire logic        temp_shutdown,
    input  wire logic [7:0]  sense_code0,
    input  wire logic [7:0]  sense_code1,
    output logic [1:0]       gate_enable,
    output logic [1:0]       soft_start_req,
    output logic [1:0]       load_current_indicator_pin,
    output logic [1:0]       ground_short_drive_pin,
    output logic [4:0]       short_level0,
    output logic [4:0]       short_level1,
    output logic             internal_supply_regulator
);

    // ========================================================
    // input synchronisers
    // ========================================================
    localparam int NS = 22;
    wire logic [NS-1:0] raw_in;
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    assign raw_in = {temp_shutdown, temp_warn, topology_select, pwm_dim,
                     ov_above, ov_below_hys, oc_above_rise, oc_below_fall,
                     ol_fb_high, ol_shunt_low, short_detect,
                     soft_start_level};

    // two stages; only the second stage is read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    wire logic       tsd_in;
    wire logic       tw_in;
    wire logic [1:0] topo_s;
    wire logic [1:0] pwm_s;
    wire logic [1:0] ovh_s;
    wire logic [1:0] ovl_s;
    wire logic [1:0] och_s;
    wire logic [1:0] ocl_s;
    wire logic [1:0] olv_s;
    wire logic [1:0] oli_s;
    wire logic [1:0] sht_s;
    wire logic [1:0] ssl_s;
    assign {tsd_in, tw_in, topo_s, pwm_s, ovh_s, ovl_s, och_s, ocl_s,
            olv_s, oli_s, sht_s, ssl_s} = sync2_r;

    // ========================================================
    // apb decode
    // ========================================================
    wire logic wr_acc;
    wire logic rd_setup;
    wire logic hit;
    wire logic clr_pulse;
    wire logic [1:0] start_pulse;
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign hit = (paddr == `OFF_FAULT0) | (paddr == `OFF_FAULT1) |
                 (paddr == `OFF_CTRL)   | (paddr == `OFF_CHECK0) |
                 (paddr == `OFF_CHECK1) | (paddr == `OFF_SETUP0) |
                 (paddr == `OFF_SETUP1);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    // clear bit is write-one, not stored
    assign clr_pulse = wr_acc & (paddr == `OFF_CTRL) & pwdata[`DB_CLR];
    assign start_pulse[0] = wr_acc & (paddr == `OFF_CHECK0) &
                            pwdata[`CB_START];
    assign start_pulse[1] = wr_acc & (paddr == `OFF_CHECK1) &
                            pwdata[`CB_START];

    // ========================================================
    // thermal supervision (shared by both channels)
    // ========================================================
    logic tsd_flag_r;
    logic tw_flag_r;

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsd_flag_r <= 1'b0;
            tw_flag_r  <= 1'b0;
        end else begin
            tsd_flag_r <= tsd_in | (tsd_flag_r & ~clr_pulse);
            tw_flag_r  <= tw_in;
        end
    end

    // regulator follows the live condition, not the latched flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) internal_supply_regulator <= 1'b0;
        else internal_supply_regulator <= ~tsd_in;
    end

    // ========================================================
    // per-channel state
    // ========================================================
    logic       ov_flag_r  [2];
    logic       oc_flag_r  [2];
    logic       ol_flag_r  [2];
    logic       sc_flag_r  [2];
    logic       ovlat_r    [2];
    logic       ov_blk_r   [2];
    logic       oc_blk_r   [2];
    logic       hold_r     [2];
    logic [2:0] ol_cnt_r   [2];
    logic       monsel_r   [2];
    logic [7:0] dac_r      [2];
    logic [3:0] code_r     [2];
    logic       done_r     [2];
    logic [1:0] res_r      [2];
    logic [CHK_W-1:0] tmr_r [2];
    fault_sup_pkg::check_state_t st_r [2];
    wire logic [7:0] sense [2];
    wire logic [4:0] lvl   [2];
    assign sense[0] = sense_code0;
    assign sense[1] = sense_code1;
    assign short_level0 = lvl[0];
    assign short_level1 = lvl[1];

    // classify sensed current against the dimming code
    function automatic logic [1:0] classify(input logic [7:0] s,
                                            input logic [7:0] d);
        logic [8:0] lo;
        logic [8:0] hi;
        logic [8:0] far;
        lo  = {1'b0, d} - {1'b0, `WIN_MARGIN};
        hi  = {1'b0, d} + {1'b0, `WIN_MARGIN};
        far = hi + {1'b0, `WIN_MARGIN};
        if (d >= `WIN_MARGIN && {1'b0, s} < lo)
            classify = fault_sup_pkg::WIN_BELOW;
        else if ({1'b0, s} <= hi)
            classify = fault_sup_pkg::WIN_INSIDE;
        else if ({1'b0, s} <= far)
            classify = fault_sup_pkg::WIN_ABOVE;
        else
            classify = fault_sup_pkg::WIN_FAR;
    endfunction

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            wire logic cfg_wr;
            wire logic chk_wr;
            wire logic fault_wr;
            wire logic ol_cond;
            wire logic ol_hit;
            wire logic hold_now;
            wire logic boost;
            wire logic ov_rel;
            wire logic run_nxt;
            assign cfg_wr   = wr_acc & (paddr == (c ? `OFF_SETUP1
                                                    : `OFF_SETUP0));
            assign chk_wr   = wr_acc & (paddr == (c ? `OFF_CHECK1
                                                    : `OFF_CHECK0));
            assign fault_wr = wr_acc & (paddr == (c ? `OFF_FAULT1
                                                    : `OFF_FAULT0));
            // open load counts only once soft start has risen far enough
            assign ol_cond = olv_s[c] & oli_s[c] & ssl_s[c];
            assign ol_hit  = ol_cond & (ol_cnt_r[c] == `OL_CYCLES);
            // thermal shutdown or short holds the stage; its end restarts
            assign hold_now = tsd_in | sht_s[c];
            // latched mode waits for software, otherwise hysteresis
            assign ov_rel = ovlat_r[c] ? (clr_pulse & ~ovh_s[c])
                                       : ovl_s[c];
            assign boost = topo_s[c];
            // code zero is the top level, the rest ascend
            assign lvl[c] = (code_r[c] == 4'h0) ? `SHORT_TOP
                                                : {1'b0, code_r[c]};

            // configuration written by software
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ovlat_r[c]  <= 1'b0;
                    monsel_r[c] <= 1'b0;
                    dac_r[c]    <= `DAC_RST;
                    code_r[c]   <= `SHORT_CODE_RST;
                end else begin
                    if (fault_wr) ovlat_r[c] <= pwdata[`FB_OVLAT];
                    if (chk_wr) begin
                        monsel_r[c] <= pwdata[`CB_MONSEL];
                        dac_r[c] <= pwdata[`CB_DAC_HI:`CB_DAC_LO];
                    end
                    if (cfg_wr) code_r[c] <= pwdata[3:0];
                end
            end

            // sticky fault flags; a new event beats the clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ov_flag_r[c] <= 1'b0;
                    oc_flag_r[c] <= 1'b0;
                    ol_flag_r[c] <= 1'b0;
                    sc_flag_r[c] <= 1'b0;
                end else begin
                    ov_flag_r[c] <= ovh_s[c] |
                                    (ov_flag_r[c] & ~clr_pulse);
                    oc_flag_r[c] <= och_s[c] |
                                    (oc_flag_r[c] & ~clr_pulse);
                    ol_flag_r[c] <= ol_hit |
                                    (ol_flag_r[c] & ~clr_pulse);
                    sc_flag_r[c] <= sht_s[c] |
                                    (sc_flag_r[c] & ~clr_pulse);
                end
            end

            // protection holds and open-load run counter
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ov_blk_r[c] <= 1'b0;
                    oc_blk_r[c] <= 1'b0;
                    hold_r[c]   <= 1'b0;
                    ol_cnt_r[c] <= 3'h0;
                end else begin
                    ov_blk_r[c] <= ovh_s[c] |
                                   (ov_blk_r[c] & ~ov_rel);
                    oc_blk_r[c] <= och_s[c] |
                                   (oc_blk_r[c] & ~ocl_s[c]);
                    hold_r[c]   <= hold_now;
                    if (!ol_cond) ol_cnt_r[c] <= 3'h0;
                    else if (!ol_hit) ol_cnt_r[c] <= ol_cnt_r[c] + 3'h1;
                end
            end

            // gate stage; open load deliberately leaves it running
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gate_enable[c]    <= 1'b0;
                    soft_start_req[c] <= 1'b0;
                end else begin
                    gate_enable[c] <= ~hold_now & ~ov_blk_r[c] &
                                      ~oc_blk_r[c];
                    soft_start_req[c] <= hold_r[c] & ~hold_now;
                end
            end

            // dual-function pin: monitor in buck or when monsel_r is set, disconnect in boost otherwise
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    load_current_indicator_pin[c] <= 1'b0;
                    ground_short_drive_pin[c]     <= 1'b0;
                end else begin
                    load_current_indicator_pin[c] <= ~boost |
                                                     monsel_r[c];
                    ground_short_drive_pin[c] <= boost & ~monsel_r[c] &
                                                 pwm_s[c] &
                                                 ~sht_s[c];
                end
            end

            // current check: start while idle, wait, then classify
            assign run_nxt = (tmr_r[c] == CHK_W'(`CHECK_CYCLES - 1));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_r[c]   <= fault_sup_pkg::CHK_IDLE;
                    tmr_r[c]  <= '0;
                    done_r[c] <= 1'b0;
                    res_r[c]  <= 2'b00;
                end else begin
                    case (st_r[c])
                        fault_sup_pkg::CHK_IDLE: begin
                            if (start_pulse[c]) begin
                                st_r[c]   <= fault_sup_pkg::CHK_RUN;
                                tmr_r[c]  <= '0;
                                done_r[c] <= 1'b0;
                            end
                        end
                        fault_sup_pkg::CHK_RUN: begin
                            tmr_r[c] <= tmr_r[c] + CHK_W'(1);
                            if (run_nxt) begin
                                st_r[c]   <= fault_sup_pkg::CHK_IDLE;
                                done_r[c] <= 1'b1;
                                res_r[c]  <= classify(sense[c],
                                                      dac_r[c]);
                            end
                        end
                        default: st_r[c] <= fault_sup_pkg::CHK_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // ========================================================
    // read mux
    // ========================================================
    wire logic [31:0] fault_rd [2];
    wire logic [31:0] chk_rd   [2];
    wire logic [31:0] ctrl_rd;
    wire logic [31:0] rd_mux;
    generate
        for (c = 0; c < 2; c++) begin : g_rd
            assign fault_rd[c] = {27'h0, ovlat_r[c], sc_flag_r[c],
                                  ol_flag_r[c], oc_flag_r[c],
                                  ov_flag_r[c]};
            assign chk_rd[c] = {16'h0, dac_r[c], 3'h0, monsel_r[c],
                                res_r[c], done_r[c], 1'b0};
        end
    endgenerate
    assign ctrl_rd = {29'h0, tsd_flag_r, tw_flag_r, 1'b0};
    assign rd_mux =
        (paddr == `OFF_FAULT0) ? fault_rd[0] :
        (paddr == `OFF_FAULT1) ? fault_rd[1] :
        (paddr == `OFF_CTRL)   ? ctrl_rd :
        (paddr == `OFF_CHECK0) ? chk_rd[0] :
        (paddr == `OFF_CHECK1) ? chk_rd[1] :
        (paddr == `OFF_SETUP0) ? {28'h0, code_r[0]} :
        (paddr == `OFF_SETUP1) ? {28'h0, code_r[1]} : 32'h0;

    // read data captured in setup so it is stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (rd_setup) prdata <= rd_mux;
    end

endmodule // fault_supervisor
`default_nettype wire

// File: bench/fault_sup_checker.sv
// port assertions for the fault supervisor
`default_nettype none
module fault_sup_checker (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [1:0] topology_select,
    input wire logic [1:0] ov_above,
    input wire logic [1:0] oc_above_rise,
    input wire logic [1:0] short_detect,
    input wire logic       temp_shutdown,
    input wire logic [1:0] gate_enable,
    input wire logic [1:0] soft_start_req,
    input wire logic [1:0] load_current_indicator_pin,
    input wire logic [4:0] short_level0,
    input wire logic       internal_supply_regulator
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // properties, all in the pclk domain
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // short seen by the sync stages, then removed, no thermal hold
    sequence s_short_end;
        $fell(short_detect[0]) && $past(short_detect[0], 3)
            && $past(presetn, 4) && !temp_shutdown;
    endsequence
    property p_short_restart;
        s_short_end |-> ##[1:5] soft_start_req[0];
    endproperty
    a_short_restart: assert property (p_short_restart)
        else $error("no soft start after short removal");
    property p_ov_gate;
        $rose(ov_above[0]) |-> ##[1:4] !gate_enable[0];
    endproperty
    a_ov_gate: assert property (p_ov_gate)
        else $error("gates still on after overvoltage");
    property p_oc_gate;
        $rose(oc_above_rise[1]) |-> ##[1:4] !gate_enable[1];
    endproperty
    a_oc_gate: assert property (p_oc_gate)
        else $error("gates still on after overcurrent");
    // thermal hold overrides every other channel state
    property p_tsd_off;
        temp_shutdown [*4] |->
            gate_enable == 2'h0 && !internal_supply_regulator;
    endproperty
    a_tsd_off: assert property (p_tsd_off)
        else $error("drivers or supply on in thermal shutdown");
    property p_supply_on;
        !temp_shutdown [*4] |-> internal_supply_regulator;
    endproperty
    a_supply_on: assert property (p_supply_on)
        else $error("supply regulator did not restart");
    property p_ss_pulse;
        soft_start_req[0] |=> !soft_start_req[0];
    endproperty
    a_ss_pulse: assert property (p_ss_pulse)
        else $error("soft start request longer than one cycle");
    property p_buck_mon;
        !topology_select[0] [*4] |-> load_current_indicator_pin[0];
    endproperty
    a_buck_mon: assert property (p_buck_mon)
        else $error("buck channel pin not a current monitor");
    property p_level;
        short_level0 inside {[5'h01:5'h10]};
    endproperty
    a_level: assert property (p_level)
        else $error("short level outside the sixteen steps");
    property p_apb;
        psel && penable && paddr[1:0] == 2'h0 |->
            pready && (pslverr == (paddr > 8'h18));
    endproperty
    a_apb: assert property (p_apb)
        else $error("bad ready or error answer");
endmodule // fault_sup_checker
bind fault_supervisor fault_sup_checker chk_u (.*);
`default_nettype wire

// File: bench/host_model.sv
// apb master model standing in for the host microcontroller
`default_nettype none
`include "fault_sup_params.svh"
module host_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // bus idle from time zero
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer; stalls are honoured, only the watchdog ends them
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // software clear, the only way out of a latched overvoltage
    task automatic clear_latched();
        logic [31:0] q;
        logic        e;
        xfer(1'b1, `OFF_CTRL, 32'h1 << `DB_CLR, q, e);
    endtask
    // start a current check and poll until the result is valid
    task automatic run_check(input logic [7:0] a, input logic [31:0] v,
                             output logic [31:0] q, output int n);
        logic e;
        xfer(1'b1, a, v | (32'h1 << `CB_START), q, e);
        n = 0;
        q = 32'h0;
        while (q[`CB_DONE] !== 1'b1) begin
            xfer(1'b0, a, 32'h0, q, e);
            n++;
        end
    endtask
endmodule // host_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the dual-channel fault supervisor
`default_nettype none
`include "fault_sup_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // stimulus, defaults describe a healthy running load
    logic        pclk, presetn, temp_warn = 1'b0, temp_shutdown = 1'b0;
    logic [1:0]  topology_select = 2'h0, pwm_dim = 2'h0;
    logic [1:0]  ov_above = 2'h0, ov_below_hys = 2'h3;
    logic [1:0]  oc_above_rise = 2'h0, oc_below_fall = 2'h3;
    logic [1:0]  ol_fb_high = 2'h0, ol_shunt_low = 2'h0;
    logic [1:0]  short_detect = 2'h0, soft_start_level = 2'h3;
    logic [7:0]  sense_code0 = 8'h00, sense_code1 = 8'h00, paddr;
    logic        psel, penable, pwrite, pready, pslverr, e, supply;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  gate_enable, ss_req, mon_pin, gnd_pin;
    logic [4:0]  short_level0, short_level1;
    int          failures = 0, n_compared = 0, n;
    logic [7:0]  sv [6] = '{8'h3b, 8'h3c, 8'h44, 8'h45, 8'h48, 8'h49};
    logic [1:0]  rv [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    fault_supervisor #(.CHK_W(8)) dut_u (.*, .soft_start_req(ss_req),
        .load_current_indicator_pin(mon_pin),
        .ground_short_drive_pin(gnd_pin), .internal_supply_regulator(supply));
    host_model host_u (.*);
    // ========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        host_u.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q, e);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // pulse looked for at the falling edge, clear of update races
    task automatic see_pulse(input int ch, input string nm);
        n = 0;
        @(negedge pclk);
        while (ss_req[ch] !== 1'b1 && n < 8) begin
            @(negedge pclk);
            n++;
        end
        chk(nm, ss_req[ch], 1'b1);
        @(posedge pclk);
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        rd(`OFF_SETUP1);
        chk("setup1 reset", q, 32'h2);
        rd(8'h1c);
        chk("unmapped err", e, 1'b1);
        chk("unmapped data", q, 32'h0);
        for (int c = 0; c < 16; c++) begin
            wr(`OFF_SETUP0, c);
            chk("level0", short_level0, (c == 0) ? 16 : c);
        end
        chk("level1", short_level1, 5'h02);
        $display("test regs done");
    endtask
    task automatic t_ov();
        ov_above[0] <= 1'b1;
        ov_below_hys[0] <= 1'b0;
        cyc(5);
        chk("ov gates", gate_enable, 2'h2);
        ov_above[0] <= 1'b0;
        cyc(5);
        chk("ov hys hold", gate_enable, 2'h2);
        ov_below_hys[0] <= 1'b1;
        cyc(5);
        chk("ov resume", gate_enable, 2'h3);
        rd(`OFF_FAULT0);
        chk("ov flag", q, 32'h1);
        wr(`OFF_FAULT0, 32'h10);
        host_u.clear_latched();
        ov_above[0] <= 1'b1;
        ov_below_hys[0] <= 1'b0;
        cyc(5);
        ov_above[0] <= 1'b0;
        ov_below_hys[0] <= 1'b1;
        cyc(5);
        chk("ov latched", gate_enable, 2'h2);
        host_u.clear_latched();
        cyc(4);
        chk("ov unlatched", gate_enable, 2'h3);
        rd(`OFF_FAULT0);
        chk("ov cleared", q, 32'h10);
        $display("test ov done");
    endtask
    task automatic t_oc();
        oc_above_rise[1] <= 1'b1;
        oc_below_fall[1] <= 1'b0;
        cyc(5);
        chk("oc gates", gate_enable, 2'h1);
        oc_above_rise[1] <= 1'b0;
        cyc(5);
        chk("oc hys hold", gate_enable, 2'h1);
        oc_below_fall[1] <= 1'b1;
        cyc(5);
        chk("oc resume", gate_enable, 2'h3);
        rd(`OFF_FAULT1);
        chk("oc flag", q, 32'h2);
        host_u.clear_latched();
        $display("test oc done");
    endtask
    // open load masked in soft start, then one short of, then full count
    task automatic t_ol();
        soft_start_level[0] <= 1'b0;
        {ol_fb_high[0], ol_shunt_low[0]} <= 2'h3;
        cyc(12);
        ol_shunt_low[0] <= 1'b0;
        soft_start_level[0] <= 1'b1;
        rd(`OFF_FAULT0);
        chk("ol masked", q[`FB_OL], 1'b0);
        ol_shunt_low[0] <= 1'b1;
        cyc(7);
        ol_shunt_low[0] <= 1'b0;
        rd(`OFF_FAULT0);
        chk("ol seven", q[`FB_OL], 1'b0);
        ol_shunt_low[0] <= 1'b1;
        cyc(12);
        chk("ol gates", gate_enable, 2'h3);
        rd(`OFF_FAULT0);
        chk("ol flag", q[`FB_OL], 1'b1);
        {ol_fb_high[0], ol_shunt_low[0]} <= 2'h0;
        cyc(4);
        host_u.clear_latched();
        $display("test ol done");
    endtask
    task automatic t_short();
        short_detect[0] <= 1'b1;
        cyc(5);
        chk("short gates", gate_enable, 2'h2);
        short_detect[0] <= 1'b0;
        see_pulse(0, "short restart");
        cyc(3);
        chk("short resume", gate_enable, 2'h3);
        rd(`OFF_FAULT0);
        chk("short flag", q[`FB_SHORT], 1'b1);
        host_u.clear_latched();
        $display("test short done");
    endtask
    task automatic t_therm();
        temp_warn <= 1'b1;
        cyc(4);
        rd(`OFF_CTRL);
        chk("warn on", q, 32'h2);
        temp_warn <= 1'b0;
        cyc(4);
        rd(`OFF_CTRL);
        chk("warn off", q, 32'h0);
        temp_shutdown <= 1'b1;
        cyc(5);
        chk("tsd off", {supply, gate_enable}, 3'h0);
        temp_shutdown <= 1'b0;
        see_pulse(0, "tsd restart");
        cyc(3);
        chk("tsd on", {supply, gate_enable}, 3'h7);
        rd(`OFF_CTRL);
        chk("tsd flag", q, 32'h4);
        host_u.clear_latched();
        $display("test thermal done");
    endtask
    task automatic t_check();
        for (int i = 0; i < 6; i++) begin
            sense_code0 <= sv[i];
            host_u.run_check(`OFF_CHECK0, 32'h4000, q, n);
            chk("window0", q[3:2], rv[i]);
            chk("check0", q & 32'hff03, 32'h4002);
            chk("not early", n >= 5, 1'b1);
        end
        sense_code1 <= 8'h49;
        host_u.run_check(`OFF_CHECK1, 32'h4000, q, n);
        chk("window1", q[3:2], 2'h3);
        $display("test check done");
    endtask
    task automatic t_pin();
        topology_select <= 2'h2;
        pwm_dim <= 2'h2;
        cyc(5);
        chk("pin modes", {mon_pin, gnd_pin}, 4'h6);
        short_detect[1] <= 1'b1;
        cyc(5);
        chk("pin short", gnd_pin, 2'h0);
        short_detect[1] <= 1'b0;
        wr(`OFF_CHECK1, 32'h10);
        cyc(4);
        chk("pin monitor", mon_pin, 2'h3);
        $display("test pins done");
    endtask
    // ========================================
    // clock, reset, sequence and verdict
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        presetn = 1'b0;
        cyc(5);
        presetn <= 1'b1;
        cyc(1);
        t_regs();
        t_ov();
        t_oc();
        t_ol();
        t_short();
        t_therm();
        t_check();
        t_pin();
        conclude();
    end
    // run needs about 450 cycles; over twenty times that means a hang
    initial begin
        #100us;
        failures++;
        conclude();
    end
endmodule // tb_top
`default_nettype wire
